// *** amcr_pkg.sv ***
// amcr_pkg: constants and types for the converter mode control registers
package amcr_pkg;

  // ----------------------------------------------------------------
  // bus widths and register addressing
  // ----------------------------------------------------------------
  localparam int unsigned CW_W       = 10;
  localparam int unsigned BUS_W      = 12;
  localparam int unsigned ADDR_LSB   = 10;
  localparam logic [1:0]  ADDR_CW0   = 2'h0;
  localparam logic [1:0]  ADDR_CW1   = 2'h1;
  localparam int unsigned SYNC_DEPTH = 3;

  // ----------------------------------------------------------------
  // control word zero fields
  // ----------------------------------------------------------------
  localparam int unsigned CW0_REF_BIT  = 0;
  localparam int unsigned CW0_PD_BIT   = 2;
  localparam int unsigned CW0_CFG_LSB  = 3;
  localparam int unsigned CW0_CFG_MSB  = 7;
  localparam int unsigned CW0_TEST_LSB = 8;
  localparam int unsigned CW0_TEST_MSB = 9;
  localparam logic [9:0]  CW0_RESET    = 10'h020;

  // input configuration codes on bits 7..3
  localparam logic [4:0]  CFG_SINGLE_POS = 5'h00;
  localparam logic [4:0]  CFG_SINGLE_NEG = 5'h01;
  localparam logic [4:0]  CFG_DIFF       = 5'h04;
  localparam logic [4:0]  CFG_SCAN       = 5'h11;

  // ----------------------------------------------------------------
  // control word one fields
  // ----------------------------------------------------------------
  localparam int unsigned CW1_SOFT_BIT   = 0;
  localparam int unsigned CW1_SYNC_BIT   = 1;
  localparam int unsigned CW1_STROBE_BIT = 6;
  localparam int unsigned CW1_FMT_BIT    = 7;
  localparam int unsigned CW1_OFS_BIT    = 8;
  localparam int unsigned CW1_RB_BIT     = 9;
  localparam logic [9:0]  CW1_RESET      = 10'h030;
  localparam logic [9:0]  CW1_SOFT_HOLD  = 10'h031;

  // upper bits shown on readback of each word
  localparam logic [1:0]  RB_TAG_CW0 = 2'h0;
  localparam logic [1:0]  RB_TAG_CW1 = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SINGLE_POS = 3'h0,
    MODE_SINGLE_NEG = 3'h1,
    MODE_DIFF       = 3'h2,
    MODE_SCAN       = 3'h3,
    MODE_RESERVED   = 3'h4
  } amcr_mode_t;

  typedef struct packed {
    logic [2:0]       cs_sync;
    logic [2:0]       wr_sync;
    logic [2:0]       rd_sync;
    logic [2:0][11:0] data_sync;
    logic             cs_filt;
    logic             wr_filt;
    logic             rd_filt;
    logic             rd_active;
    logic [9:0]       cw0;
    logic [9:0]       cw1;
    logic             rb_second;
    logic             scan_neg;
    logic             sync_pulse;
    logic [11:0]      sample;
    logic [11:0]      dout;
    logic             oe_n;
  } amcr_state_t;

endpackage

// *** amcr_regs.sv ***
// amcr_regs: host register interface and mode control of the converter
`timescale 1ns/1ps
`default_nettype none

module amcr_regs (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   cs_n,
  input  wire logic                   wr_n,
  input  wire logic                   rd_n,
  input  wire logic [11:0]            data_in,
  output logic      [11:0]            data_out,
  output logic                        data_oe_n,
  input  wire logic                   conv_tick,
  input  wire logic                   result_valid,
  input  wire logic [11:0]            result_raw,
  output logic                        ref_external,
  output logic                        power_down_select,
  output logic                        conv_enable,
  output amcr_pkg::amcr_mode_t        input_mode,
  output logic                        active_input_neg,
  output logic [1:0]                  check_voltage_sel,
  output logic                        offset_cal_enable,
  output logic                        output_format_select,
  output logic                        strobe_mode_rw,
  output logic                        config_readback_enable,
  output logic                        sync_gen_clear,
  output logic                        soft_reset_active
);
  import amcr_pkg::*;

  amcr_state_t state_reg;
  amcr_state_t state_next;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // input configuration decode of bits 7..3
  function automatic amcr_mode_t decode_cfg(input logic [4:0] cfg);
    amcr_mode_t m;
    m = MODE_RESERVED;
    case (cfg)
      CFG_SINGLE_POS: m = MODE_SINGLE_POS;
      CFG_SINGLE_NEG: m = MODE_SINGLE_NEG;
      CFG_DIFF:       m = MODE_DIFF;
      CFG_SCAN:       m = MODE_SCAN;
      default:        m = MODE_RESERVED;
    endcase
    return m;
  endfunction

  // three-stage filter: a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  logic        cs_new;
  logic        wr_new;
  logic        rd_new;
  logic        rw_mode;
  logic        wr_evt;
  logic        rd_new_active;
  logic        rd_start;
  logic        rd_end;
  logic [11:0] wr_word;
  logic        wr_cw0;
  logic        wr_cw1;
  logic        in_soft;

  assign cs_new  = filt(state_reg.cs_sync, state_reg.cs_filt);
  assign wr_new  = filt(state_reg.wr_sync, state_reg.wr_filt);
  assign rd_new  = filt(state_reg.rd_sync, state_reg.rd_filt);
  assign rw_mode = state_reg.cw1[CW1_STROBE_BIT];
  assign wr_word = state_reg.data_sync[2];
  assign in_soft = state_reg.cw1[CW1_SOFT_BIT];

  // write: rising write strobe, or chip select end with r/w low
  assign wr_evt = rw_mode ?
                  (cs_new && !state_reg.cs_filt && !state_reg.wr_filt) :
                  (wr_new && !state_reg.wr_filt && !state_reg.cs_filt);

  // address decode on upper data bits; power-down does not gate it
  assign wr_cw0 = wr_evt && !in_soft &&
                  (wr_word[BUS_W-1:ADDR_LSB] == ADDR_CW0);
  assign wr_cw1 = wr_evt &&
                  (wr_word[BUS_W-1:ADDR_LSB] == ADDR_CW1);

  // read window: read strobe, or r/w high in strobe mode
  assign rd_new_active = !cs_new && (rw_mode ? wr_new : !rd_new);
  assign rd_start      = rd_new_active && !state_reg.rd_active;
  assign rd_end        = !rd_new_active && state_reg.rd_active;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // input synchronisers, stage one read only by stage two
    state_next.cs_sync   = {state_reg.cs_sync[1:0], cs_n};
    state_next.wr_sync   = {state_reg.wr_sync[1:0], wr_n};
    state_next.rd_sync   = {state_reg.rd_sync[1:0], rd_n};
    state_next.data_sync = {state_reg.data_sync[1:0], data_in};
    state_next.cs_filt   = cs_new;
    state_next.wr_filt   = wr_new;
    state_next.rd_filt   = rd_new;
    state_next.rd_active = rd_new_active;
    state_next.sync_pulse = 1'b0;

    // control word zero write
    if (wr_cw0) begin
      state_next.cw0 = wr_word[CW_W-1:0];
    end

    // control word one write, soft reset bit first
    if (wr_cw1) begin
      if (wr_word[CW1_SOFT_BIT]) begin
        state_next.cw0      = CW0_RESET;
        state_next.cw1      = CW1_SOFT_HOLD;
        state_next.scan_neg = 1'b0;
      end else begin
        state_next.cw1 = wr_word[CW_W-1:0];
        state_next.sync_pulse = wr_word[CW1_SYNC_BIT];
        if (wr_word[CW1_RB_BIT] && !state_reg.cw1[CW1_RB_BIT]) begin
          state_next.rb_second = 1'b0;
        end
      end
    end

    // autoscan alternation on each conversion
    if (decode_cfg(state_reg.cw0[CW0_CFG_MSB:CW0_CFG_LSB]) == MODE_SCAN) begin
      if (conv_tick && !in_soft) begin
        state_next.scan_neg = !state_reg.scan_neg;
      end
    end else begin
      state_next.scan_neg = 1'b0;
    end

    // capture result in selected output format
    if (result_valid) begin
      if (state_reg.cw1[CW1_FMT_BIT]) begin
        state_next.sample = result_raw;
      end else begin
        state_next.sample = {~result_raw[11], result_raw[10:0]};
      end
    end

    // read data: readback words or last result
    if (rd_start) begin
      state_next.oe_n = 1'b0;
      if (state_reg.cw1[CW1_RB_BIT]) begin
        if (state_reg.rb_second) begin
          state_next.dout = {RB_TAG_CW1, state_reg.cw1};
        end else begin
          state_next.dout = {RB_TAG_CW0, state_reg.cw0};
        end
      end else begin
        state_next.dout = state_reg.sample;
      end
    end else if (rd_end) begin
      state_next.oe_n = 1'b1;
      if (state_reg.cw1[CW1_RB_BIT]) begin
        state_next.rb_second = !state_reg.rb_second;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg            <= '0;
      state_reg.cs_sync    <= 3'h7;
      state_reg.wr_sync    <= 3'h7;
      state_reg.rd_sync    <= 3'h7;
      state_reg.cs_filt    <= 1'b1;
      state_reg.wr_filt    <= 1'b1;
      state_reg.rd_filt    <= 1'b1;
      state_reg.cw0        <= CW0_RESET;
      state_reg.cw1        <= CW1_RESET;
      state_reg.oe_n       <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_out               = state_reg.dout;
  assign data_oe_n              = state_reg.oe_n;
  assign ref_external           = state_reg.cw0[CW0_REF_BIT];
  assign power_down_select      = state_reg.cw0[CW0_PD_BIT];
  assign conv_enable            = !power_down_select && !in_soft;
  assign input_mode = decode_cfg(state_reg.cw0[CW0_CFG_MSB:CW0_CFG_LSB]);
  assign active_input_neg       = (input_mode == MODE_SINGLE_NEG) ||
                                  (input_mode == MODE_SCAN &&
                                   state_reg.scan_neg);
  assign check_voltage_sel = state_reg.cw0[CW0_TEST_MSB:CW0_TEST_LSB];
  assign offset_cal_enable      = state_reg.cw1[CW1_OFS_BIT];
  assign output_format_select   = state_reg.cw1[CW1_FMT_BIT];
  assign strobe_mode_rw         = rw_mode;
  assign config_readback_enable = state_reg.cw1[CW1_RB_BIT];
  assign sync_gen_clear         = state_reg.sync_pulse;
  assign soft_reset_active      = in_soft;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_ref_from_write: assert property (
    wr_cw0 |=> ref_external == $past(wr_word[0]))
    else $error("reference select not taken from write");

  a_pd_from_write: assert property (
    wr_cw0 |=> power_down_select == $past(wr_word[2]))
    else $error("power-down bit not taken from write");

  a_pd_still_reads: assert property (
    (power_down_select && rd_start) |=> !data_oe_n)
    else $error("read refused during power-down");

  a_diff_decode: assert property (
    (state_reg.cw0[7:3] == 5'h04) |-> (input_mode == MODE_DIFF)
      && !active_input_neg)
    else $error("differential code decoded wrongly");

  a_single_neg_decode: assert property (
    (state_reg.cw0[7:3] == 5'h01) |-> input_mode == MODE_SINGLE_NEG
      && active_input_neg)
    else $error("negative single code decoded wrongly");

  a_scan_alternates: assert property (
    (input_mode == MODE_SCAN && conv_tick && !in_soft && !wr_evt)
      |=> active_input_neg != $past(active_input_neg))
    else $error("autoscan did not alternate");

  a_soft_holds_reset: assert property (
    soft_reset_active |-> state_reg.cw0 == 10'h020 && !conv_enable)
    else $error("soft reset not holding word zero");

  a_sync_one_pulse: assert property (
    (wr_cw1 && wr_word[1] && !wr_word[0])
      |=> sync_gen_clear ##1 !sync_gen_clear)
    else $error("sync clear not a single pulse");

  a_twos_format: assert property (
    (result_valid && !output_format_select)
      |=> state_reg.sample[11] == !$past(result_raw[11]))
    else $error("twos complement msb wrong");

  a_reserved_addr: assert property (
    (wr_evt && wr_word[11]) |=> $stable(state_reg.cw0)
      && $stable(state_reg.cw1))
    else $error("reserved address changed a word");

  a_rb_first_cw0: assert property (
    (config_readback_enable && rd_start && !state_reg.rb_second)
      |=> data_out[11:10] == 2'h0 && !data_oe_n)
    else $error("first readback is not word zero");

  a_cfg_from_write: assert property (
    wr_cw0 |=> state_reg.cw0[7:3] == $past(wr_word[7:3]))
    else $error("input configuration not taken from write");

  a_test_from_write: assert property (
    wr_cw0 |=> check_voltage_sel == $past(wr_word[9:8]))
    else $error("test voltage select not taken from write");

  a_soft_loads_reset: assert property (
    (wr_cw1 && wr_word[0]) |=> state_reg.cw0 == CW0_RESET
      && soft_reset_active && !conv_enable)
    else $error("soft reset write did not reload the words");

  a_binary_format: assert property (
    (result_valid && output_format_select)
      |=> state_reg.sample == $past(result_raw))
    else $error("binary result not passed straight");

  c_scan_mode: cover property (input_mode == MODE_SCAN && conv_tick);
  c_rw_read: cover property (rw_mode && rd_start);
  c_soft_reset: cover property (wr_cw1 && wr_word[0]);
  c_readback: cover property (config_readback_enable && rd_end);
  c_rw_write: cover property (rw_mode && wr_evt);

endmodule

`default_nettype wire

// *** amcr_host.sv ***
// amcr_host: host processor model on the parallel bus pins
`timescale 1ns/1ps
`default_nettype none
module amcr_host (
  input  wire logic        clk,
  input  wire logic        rw_mode,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe_n,
  output logic             cs_n,
  output logic             wr_n,
  output logic             rd_n,
  output logic [11:0]      data_in
);
  logic [11:0] bus_val;
  // pin level: device data while its enable is low
  assign data_in = data_oe_n ? bus_val : data_out;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    bus_val = 12'h000;
  end
  // wait edges, then move pins just after
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one whole word, address on the top bits
  task automatic write_word(input logic [1:0] a, input logic [9:0] v);
    step(1);
    bus_val = {a, v};
    if (rw_mode) begin
      wr_n = 1'b0;
      step(1);
      cs_n = 1'b0;
      step(6);
      cs_n = 1'b1;
    end else begin
      cs_n = 1'b0;
      step(1);
      wr_n = 1'b0;
      step(6);
      wr_n = 1'b1;
    end
    step(5);
    cs_n = 1'b1;
    wr_n = 1'b1;
    bus_val = ~bus_val; // released bus keeps no stale value
    step(5);
  endtask
  // read strobe held until data shows, then released
  task automatic read_word(output logic [11:0] v);
    int n;
    step(1);
    cs_n = 1'b0;
    rd_n = rw_mode; // r/w mode leaves it high
    n = 0;
    while (data_oe_n !== 1'b0 && n < 12) begin
      step(1);
      n++;
    end
    step(2);
    v = (n < 12) ? data_out : 12'hXXX;
    step(3);
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(10);
  endtask
endmodule
`default_nettype wire

// *** amcr_regs_tb.sv ***
// amcr_regs_tb: self-checking bench for the converter mode registers
`timescale 1ns/1ps
`default_nettype none
module amcr_regs_tb;
  import amcr_pkg::*;
  localparam logic [4:0] CODES [4] = '{5'h00, 5'h01, 5'h04, 5'h11};
  logic       clk, reset, cs_n, wr_n, rd_n, data_oe_n, rw_mode;
  logic       conv_tick, result_valid, ref_external, power_down_select;
  logic       conv_enable, active_input_neg, offset_cal_enable;
  logic       output_format_select, strobe_mode_rw, sync_gen_clear;
  logic       config_readback_enable, soft_reset_active;
  logic [1:0] check_voltage_sel;
  logic [11:0] data_in, data_out, result_raw, rd_val;
  logic [9:0] cw0_exp, cw1_exp;
  amcr_mode_t input_mode;
  int         fail_count, compares, sync_count;

  amcr_regs uut (.clk(clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .conv_tick(conv_tick),
    .result_valid(result_valid), .result_raw(result_raw),
    .ref_external(ref_external), .power_down_select(power_down_select),
    .conv_enable(conv_enable), .input_mode(input_mode),
    .active_input_neg(active_input_neg),
    .check_voltage_sel(check_voltage_sel),
    .offset_cal_enable(offset_cal_enable),
    .output_format_select(output_format_select),
    .strobe_mode_rw(strobe_mode_rw),
    .config_readback_enable(config_readback_enable),
    .sync_gen_clear(sync_gen_clear),
    .soft_reset_active(soft_reset_active));
  amcr_host host (.clk(clk), .rw_mode(rw_mode), .data_out(data_out),
    .data_oe_n(data_oe_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .data_in(data_in));

  // clock and sync pulse counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sync_gen_clear === 1'b1) sync_count++;
  end

  // comparison and expectation helpers
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic amcr_mode_t mode_of(input logic [4:0] c);
    case (c)
      5'h00: return MODE_SINGLE_POS;
      5'h01: return MODE_SINGLE_NEG;
      5'h04: return MODE_DIFF;
      5'h11: return MODE_SCAN;
      default: return MODE_RESERVED;
    endcase
  endfunction
  task automatic check_cw0();
    logic [4:0] c;
    logic       e;
    c = cw0_exp[7:3];
    e = !cw0_exp[2] && !cw1_exp[0];
    check("ref", {11'h0, ref_external}, {11'h0, cw0_exp[0]});
    check("pd", {11'h0, power_down_select}, {11'h0, cw0_exp[2]});
    check("mode", {9'h0, input_mode}, {9'h0, mode_of(c)});
    check("test", {10'h0, check_voltage_sel}, {10'h0, cw0_exp[9:8]});
    check("en", {11'h0, conv_enable}, {11'h0, e});
    if (c != 5'h11) begin
      check("neg", {11'h0, active_input_neg}, {11'h0, c == 5'h01});
    end
  endtask
  task automatic check_cw1();
    check("cw1", {7'h0, config_readback_enable, offset_cal_enable,
      output_format_select, strobe_mode_rw, soft_reset_active},
      {7'h0, cw1_exp[9:6], cw1_exp[0]});
  endtask
  task automatic wr0(input logic [9:0] v);
    host.write_word(2'h0, v);
    if (!cw1_exp[0]) cw0_exp = v;
  endtask
  task automatic wr1(input logic [9:0] v);
    host.write_word(2'h1, v);
    cw1_exp = v[0] ? 10'h031 : v;
    if (v[0]) cw0_exp = 10'h020;
    rw_mode = cw1_exp[6];
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic        p;
    void'($urandom(32'h00961760));
    {reset, conv_tick, result_valid, rw_mode} = 4'h8;
    {fail_count, compares, sync_count} = '0;
    {result_raw, cw0_exp, cw1_exp} = {12'h000, 10'h020, 10'h030};
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    check_cw0();
    check_cw1();
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      wr0({r[9:8], CODES[i % 4], r[2], 1'b0, r[0]});
      check_cw0();
      host.write_word(2'h2 + 2'(i % 2), ~r[9:0]);
      check_cw0();
    end
    wr0(10'h088);
    for (int i = 0; i < 5; i++) begin
      p = active_input_neg;
      @(posedge clk);
      #1 conv_tick = 1'b1;
      @(posedge clk);
      #1 conv_tick = 1'b0;
      @(posedge clk);
      #1 check("scan", {11'h0, active_input_neg}, {11'h0, ~p});
    end
    wr0(10'h024);
    check_cw0();
    wr1(10'h200);
    host.read_word(rd_val);
    check("rb0", rd_val, {2'h0, cw0_exp});
    host.read_word(rd_val);
    check("rb1", rd_val, {2'h1, cw1_exp});
    host.read_word(rd_val);
    check("rb2", rd_val, {2'h0, cw0_exp});
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr1({1'b0, r[8], i[0], 7'h00});
      check_cw1();
      @(posedge clk);
      #1 {result_valid, result_raw} = {1'b1, r[27:16]};
      @(posedge clk);
      #1 result_valid = 1'b0;
      host.read_word(rd_val);
      check("fmt", rd_val, {r[27] ^ !i[0], r[26:16]});
    end
    sync_count = 0;
    wr1(10'h002);
    check("sync", 12'(sync_count), 12'h001);
    wr0(10'h301);
    wr1(10'h001);
    check_cw0();
    check_cw1();
    wr0(10'h005);
    check_cw0();
    wr1(10'h000);
    check_cw1();
    wr1(10'h040);
    check_cw1();
    host.read_word(rd_val);
    check("rwrd", rd_val, r[27:16]);
    wr0(10'h10D);
    check_cw0();
    wr1(10'h000);
    check_cw1();
    results();
  end

  // watchdog far beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
